// *** src/wwdc_pkg.sv ***
// Shared constants and types for the windowed watchdog control block
package wwdc_pkg;

   // Bus geometry
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
   localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h004;
   localparam logic [ADDR_W-1:0] RESTART_OFF = 12'h008;

   // Control register field positions
   localparam int SOFT_BIT = 0;
   localparam int IVL_LSB = 1;
   localparam int IVL_MSB = 5;

   // Status register field positions
   localparam int ST_RUN_BIT = 0;
   localparam int ST_CODE_LSB = 1;
   localparam int ST_CODE_MSB = 5;
   localparam int ST_LOCK_BIT = 6;
   localparam int ST_MODE_LSB = 8;
   localparam int ST_MODE_MSB = 9;

   // Interval select codes
   localparam int CODE_W = 5;
   localparam logic [CODE_W-1:0] CODE_ALL_ONES = 5'h1f;
   localparam logic [CODE_W-1:0] INTERVAL_RST = 5'h0b;
   localparam logic [CODE_W-1:0] CODE_MAX = 5'h12;
   localparam logic [CODE_W-1:0] CODE_MIN = 5'h00;
   localparam logic [CODE_W-1:0] SHIFT_BASE = 5'h05;

   // Enable mode encodings
   localparam int MODE_W = 2;
   localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
   localparam logic [MODE_W-1:0] MODE_SOFT = 2'h1;

   // Values after reset
   localparam logic SOFT_RST = 1'b0;
   localparam logic [MODE_W-1:0] MODE_RST = 2'h0;

   // Prescale counter width: largest ratio is 2**23
   localparam int CNT_W = 24;

   // Clock rates; the count runs on oscillator periods, not bus clocks
   localparam int CLK_HZ = 10_000_000;
   localparam int OSC_HZ = 31_000;
   localparam int OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;

   // Bus response
   localparam logic HRESP_OKAY = 1'b0;

   // Bus slave phase
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WR_DATA,
      BUS_RD_WAIT,
      BUS_RD_DONE
   } wwdc_bus_t;

endpackage : wwdc_pkg

// *** src/wwdc_tick_if.sv ***
// Link between control, oscillator synchroniser and prescale counter
`timescale 1ns/1ps
interface wwdc_tick_if;
   import wwdc_pkg::*;

   logic osc_tick; // One pulse per oscillator rising edge
   logic run; // Watchdog switched on
   logic [CODE_W-1:0] ratio_code; // Effective interval code
   logic restart; // Clear the count
   logic timeout; // One pulse when the interval expires

   modport ctrl (input osc_tick, input timeout, output run, output ratio_code, output restart);
   modport sync (output osc_tick);
   modport cnt (input osc_tick, input run, input ratio_code, input restart, output timeout);
endinterface : wwdc_tick_if

// *** src/wwdc_osc_sync.sv ***
// Synchroniser and rising-edge detector for the low-frequency oscillator
`timescale 1ns/1ps
module wwdc_osc_sync (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic low_freq_internal_osc,
   wwdc_tick_if.sync link
);
   import wwdc_pkg::*;

   logic s1_q; // First stage, read only by the second
   logic s2_q;
   logic s3_q;
   logic level_q; // Filtered oscillator level
   logic tick_q; // Rising-edge pulse

   // Three-stage chain; the oscillator is asynchronous to ref_clk
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= low_freq_internal_osc;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts only once stages two and three agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         level_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (s2_q == s3_q && s3_q != level_q) begin
            level_q <= s3_q;
            tick_q <= s3_q;
         end
      end
   end

   assign link.osc_tick = tick_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_tick_on_agree: assert property (
      tick_q |-> $past(s2_q) && $past(s3_q) && !$past(level_q))
      else $error("oscillator tick without agreed rising edge");
   a_tick_single: assert property (tick_q |=> !tick_q)
      else $error("oscillator tick longer than one cycle");
   c_osc_tick: cover property (tick_q ##1 !tick_q [*3] ##1 level_q);

endmodule : wwdc_osc_sync

// *** src/wwdc_prescaler.sv ***
// Prescale counter of oscillator periods with timeout pulse
`timescale 1ns/1ps
module wwdc_prescaler #(
   parameter int CNT_WIDTH = wwdc_pkg::CNT_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   wwdc_tick_if.cnt link
);
   import wwdc_pkg::*;

   // Counter must hold the largest ratio
   if (CNT_WIDTH < int'(SHIFT_BASE) + int'(CODE_MAX) + 1) begin : g_bad_width
      $error("prescale counter too narrow for the largest ratio");
   end

   logic [CNT_WIDTH-1:0] count_q; // Oscillator periods counted
   logic [CNT_WIDTH-1:0] terminal; // Last count before expiry
   logic [CODE_W-1:0] shift; // log2 of the ratio
   logic timeout_q;

   // Ratio is 2**(5+code): code 0 gives 32, each step doubles
   always_comb begin
      shift = link.ratio_code + SHIFT_BASE;
      terminal = ({{(CNT_WIDTH-1){1'b0}}, 1'b1} << shift) - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
   end

   // Count only on oscillator ticks, so timing follows the oscillator
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
         timeout_q <= 1'b0;
      end else begin
         timeout_q <= 1'b0;
         if (!link.run || link.restart) begin
            count_q <= '0;
         end else if (link.osc_tick) begin
            if (count_q == terminal) begin
               count_q <= '0;
               timeout_q <= 1'b1;
            end else begin
               count_q <= count_q + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   assign link.timeout = timeout_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_terminal_expiry: assert property (
      link.osc_tick && link.run && !link.restart && count_q == terminal
      |=> timeout_q && count_q == '0)
      else $error("timeout missing at terminal count");
   a_expiry_exact: assert property (
      timeout_q |-> $past(count_q) == ({{(CNT_WIDTH-1){1'b0}}, 1'b1}
         << ($past(link.ratio_code) + SHIFT_BASE)) - {{(CNT_WIDTH-1){1'b0}}, 1'b1})
      else $error("timeout at wrong count for the selected ratio");
   c_expiry: cover property (timeout_q);

endmodule : wwdc_prescaler

// *** src/wwdc_top.sv ***
// Windowed watchdog control register with AHB-Lite slave and prescaler
`timescale 1ns/1ps

module wwdc_top (
   input wire logic ref_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [wwdc_pkg::DATA_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [wwdc_pkg::DATA_W-1:0] hwdata,
   output logic [wwdc_pkg::DATA_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Configuration word fields, static while running
   input wire logic [wwdc_pkg::CODE_W-1:0] config_interval_default,
   input wire logic [wwdc_pkg::MODE_W-1:0] watchdog_enable_mode,
   // Oscillator pin and watchdog outputs
   input wire logic low_freq_internal_osc,
   output logic watchdog_on,
   output logic watchdog_timeout
);
   import wwdc_pkg::*;

   wwdc_tick_if u_link ();

   // Bus slave state
   wwdc_bus_t bus_q; // Current data phase
   wwdc_bus_t bus_d;
   logic [ADDR_W-1:0] addr_q; // Offset of the access in flight
   logic [DATA_W-1:0] hrdata_q; // Read data, loaded in the wait cycle
   logic accept; // Address phase taken this cycle

   // Configuration capture
   logic init_q; // High for the first cycle after reset release
   logic [CODE_W-1:0] cfg_default_q; // Captured default interval
   logic [MODE_W-1:0] mode_q; // Captured enable mode
   logic locked; // Interval field read-only

   // Control state
   logic [CODE_W-1:0] interval_q; // Interval select field
   logic soft_q; // Software enable bit
   logic run_q; // Watchdog switched on
   logic run_d;
   logic [CODE_W-1:0] ratio_code; // Code after reserved fallback
   logic timeout_q;

   // Write strobes in the data phase
   logic wr_ctrl;
   logic wr_restart;

   // Only NONSEQ/SEQ with the bus ready start a transfer
   assign accept = hsel && htrans[1] && hready;

   // Reads get one wait state so a write just before is visible
   always_comb begin
      bus_d = BUS_IDLE;
      unique case (bus_q)
         BUS_RD_WAIT: begin
            bus_d = BUS_RD_DONE;
         end
         BUS_IDLE, BUS_WR_DATA, BUS_RD_DONE: begin
            if (accept) begin
               bus_d = hwrite ? BUS_WR_DATA : BUS_RD_WAIT;
            end
         end
      endcase
   end

   // Phase register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_q <= BUS_IDLE;
      end else begin
         bus_q <= bus_d;
      end
   end

   // Address held for the data phase; upper address bits alias
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         addr_q <= '0;
      end else if (accept && bus_q != BUS_RD_WAIT) begin
         addr_q <= haddr[ADDR_W-1:0];
      end
   end

   assign wr_ctrl = (bus_q == BUS_WR_DATA) && (addr_q == CTRL_OFF);
   assign wr_restart = (bus_q == BUS_WR_DATA) && (addr_q == RESTART_OFF);

   // Read data; unmapped offsets and the restart register read zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hrdata_q <= '0;
      end else if (bus_q == BUS_RD_WAIT) begin
         hrdata_q <= '0;
         if (addr_q == CTRL_OFF) begin
            hrdata_q[IVL_MSB:IVL_LSB] <= interval_q;
            hrdata_q[SOFT_BIT] <= soft_q;
         end else if (addr_q == STATUS_OFF) begin
            hrdata_q[ST_RUN_BIT] <= run_q;
            hrdata_q[ST_CODE_MSB:ST_CODE_LSB] <= ratio_code;
            hrdata_q[ST_LOCK_BIT] <= locked;
            hrdata_q[ST_MODE_MSB:ST_MODE_LSB] <= mode_q;
         end
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = (bus_q != BUS_RD_WAIT);
   assign hresp = HRESP_OKAY;

   // One-cycle marker after reset release for configuration capture
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         init_q <= 1'b1;
      end else begin
         init_q <= 1'b0;
      end
   end

   // Config word sampled once after release, never under reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_default_q <= CODE_ALL_ONES;
         mode_q <= MODE_RST;
      end else if (init_q) begin
         cfg_default_q <= config_interval_default;
         mode_q <= watchdog_enable_mode;
      end
   end

   assign locked = (cfg_default_q != CODE_ALL_ONES);

   // Interval field: reset default, config load, then software
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         interval_q <= INTERVAL_RST;
      end else if (init_q) begin
         if (config_interval_default == CODE_ALL_ONES) begin
            interval_q <= INTERVAL_RST;
         end else begin
            interval_q <= config_interval_default;
         end
      end else if (wr_ctrl && !locked) begin
         interval_q <= hwdata[IVL_MSB:IVL_LSB];
      end
   end

   // Software enable bit; cleared by every reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         soft_q <= SOFT_RST;
      end else if (wr_ctrl) begin
         soft_q <= hwdata[SOFT_BIT];
      end
   end

   // Reserved codes fall back to the shortest ratio
   always_comb begin
      if (interval_q > CODE_MAX) begin
         ratio_code = CODE_MIN;
      end else begin
         ratio_code = interval_q;
      end
   end

   // Mode 1x forces on, 00 forces off, 01 follows the soft bit
   always_comb begin
      if (mode_q[1]) begin
         run_d = 1'b1;
      end else if (mode_q == MODE_SOFT) begin
         run_d = soft_q;
      end else begin
         run_d = 1'b0;
      end
   end

   // Registered run state drives the counter and the pin
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_q <= 1'b0;
      end else begin
         run_q <= run_d;
      end
   end

   // Timeout pin registered again for a clean data output
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timeout_q <= 1'b0;
      end else begin
         timeout_q <= u_link.timeout;
      end
   end

   // Any control register write or an explicit restart clears the count
   assign u_link.run = run_q;
   assign u_link.ratio_code = ratio_code;
   assign u_link.restart = wr_restart || wr_ctrl;

   assign watchdog_on = run_q;
   assign watchdog_timeout = timeout_q;

   // Oscillator edge detector
   wwdc_osc_sync u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .low_freq_internal_osc(low_freq_internal_osc),
      .link(u_link.sync)
   );

   // Prescale counter
   wwdc_prescaler #(
      .CNT_WIDTH(CNT_W)
   ) u_cnt (
      .ref_clk(ref_clk),
      .rst(rst),
      .link(u_link.cnt)
   );

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_reserved_fallback: assert property (
      (interval_q > CODE_MAX) |-> (u_link.ratio_code == CODE_MIN))
      else $error("reserved interval code not mapped to 1:32");

   a_reset_default: assert property (
      init_q && config_interval_default == CODE_ALL_ONES |=> interval_q == INTERVAL_RST)
      else $error("interval did not take 01011 after reset");

   a_reset_follow: assert property (
      init_q && config_interval_default != CODE_ALL_ONES
      |=> interval_q == $past(config_interval_default) && locked)
      else $error("interval did not follow config default after reset");

   a_locked_write: assert property (
      wr_ctrl && locked |=> $stable(interval_q))
      else $error("write changed a locked interval field");

   a_open_write: assert property (
      wr_ctrl && !locked |=> interval_q == $past(hwdata[IVL_MSB:IVL_LSB]))
      else $error("write to open interval field lost");

   a_soft_gate: assert property (
      wr_ctrl && mode_q == MODE_SOFT && !init_q
      |=> ##1 watchdog_on == $past(hwdata[SOFT_BIT], 2))
      else $error("soft enable not followed in mode 01");

   a_mode_fixed: assert property (
      !init_q && mode_q != MODE_SOFT |=> watchdog_on == mode_q[1])
      else $error("soft enable acted outside mode 01");

   a_ctrl_upper_zero: assert property (
      bus_q == BUS_RD_DONE && addr_q == CTRL_OFF |-> hrdata[DATA_W-1:IVL_MSB+1] == '0)
      else $error("control register upper bits not zero");

   a_soft_after_reset: assert property (
      init_q |-> !soft_q && !watchdog_on)
      else $error("soft enable not cleared by reset");

   a_read_wait: assert property (
      accept && !hwrite && bus_q != BUS_RD_WAIT |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait state");

   c_ctrl_write: cover property (wr_ctrl && !locked);
   c_soft_on: cover property (mode_q == MODE_SOFT && $rose(watchdog_on));
   c_timeout: cover property (watchdog_on ##[1:1000] watchdog_timeout);

endmodule : wwdc_top

// *** testbench/wwdc_tb.sv ***
// Self-checking bench for the windowed watchdog control block
`timescale 1ns/1ps
module testbench;
   import wwdc_pkg::*;

   logic ref_clk = 1'b0; // Bus clock
   logic rst = 1'b1; // Asynchronous reset
   logic hsel = 1'b0; // Slave select
   logic [DATA_W-1:0] haddr = '0; // Byte address
   logic [1:0] htrans = 2'h0; // Transfer type
   logic hwrite = 1'b0; // Direction
   logic [2:0] hsize = 3'h2; // Word transfers only
   logic [DATA_W-1:0] hwdata = '0; // Write data
   logic [DATA_W-1:0] hrdata; // Read data
   logic hreadyout; // Slave ready, fed back as bus ready
   logic hresp; // Response, always OKAY
   logic [CODE_W-1:0] cfg_code = 5'h1f; // Config default interval
   logic [MODE_W-1:0] cfg_mode = 2'h1; // Config enable mode
   logic osc = 1'b0; // Slow oscillator pin
   logic watchdog_on; // Watchdog running
   logic watchdog_timeout; // Expiry pulse
   int osc_div = 0; // Half period counter
   int osc_rises = 0; // Oscillator rising edges so far
   int num_errors = 0; // Mismatches
   int n_tests = 0; // Comparisons
   logic [DATA_W-1:0] rd; // Last read word
   logic [MODE_W-1:0] mode; // Mode under test
   int rise0; // Rise count at count clear

   // Free-running bus clock
   always #50 ref_clk = ~ref_clk;

   // Oscillator from divided bus clock; its phase drifts against bus traffic
   always @(posedge ref_clk) begin
      if (osc_div == OSC_PERIOD_CYC / 2 - 1) begin
         osc_div <= 0;
         osc <= ~osc;
         if (!osc) begin
            osc_rises <= osc_rises + 1;
         end
      end else begin
         osc_div <= osc_div + 1;
      end
   end

   wwdc_top wwdc_top_inst (
      .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .config_interval_default(cfg_code), .watchdog_enable_mode(cfg_mode),
      .low_freq_internal_osc(osc), .watchdog_on(watchdog_on),
      .watchdog_timeout(watchdog_timeout)
   );

   // Counts, verdict and end of run
   task automatic give_verdict();
      $display("Comparisons: %0d, mismatches: %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Compare one word, four-state exact
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                        input string what);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // Advance edges until ready is sampled high; a hang ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         $display("ERROR %0t: bus never ready", $time);
         give_verdict();
      end
   endtask : wait_ready

   // Single word write; entered just after a rising edge
   task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask : bus_write

   // Single word read; data taken at the edge that ends the data phase
   task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      wait_ready();
      d = hrdata;
   endtask : bus_read

   // Reset with a given configuration word; config held stable across release
   task automatic do_reset(input logic [CODE_W-1:0] code, input logic [MODE_W-1:0] m);
      rst <= 1'b1;
      cfg_code <= code;
      cfg_mode <= m;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
   endtask : do_reset

   // Write code with soft enable set, then count oscillator periods to expiry
   task automatic measure(input logic [CODE_W-1:0] code, input int ratio);
      int n;
      int d;
      n = 0;
      bus_write(CTRL_OFF, {26'h0, code, 1'b1});
      rise0 = osc_rises;
      do begin
         @(posedge ref_clk);
         n++;
      end while (watchdog_timeout !== 1'b1 && n < (ratio + 4) * OSC_PERIOD_CYC);
      d = osc_rises - rise0;
      n_tests++;
      // Pin-to-tick lag may hide one rise just before the clear
      if (watchdog_timeout !== 1'b1 || d < ratio - 1 || d > ratio) begin
         num_errors++;
         $display("ERROR %0t: expiry after %0d periods, expected %0d", $time, d, ratio);
         give_verdict();
      end
      @(posedge ref_clk);
      check({31'h0, watchdog_timeout}, 32'h0, "expiry pulse width");
   endtask : measure

   // Main sequence
   initial begin
      // Unlocked interval, soft mode
      do_reset(5'h1f, 2'h1);
      bus_read(CTRL_OFF, rd);
      check(rd, {26'h0, INTERVAL_RST, 1'b0}, "ctrl after reset");
      bus_write(CTRL_OFF, 32'hffff_ffc3);
      bus_read(CTRL_OFF, rd);
      check(rd, 32'h0000_0003, "ctrl upper bits");
      bus_read(STATUS_OFF, rd);
      check(rd, 32'h0000_0103, "status soft on");
      check({31'h0, watchdog_on}, 32'h1, "soft on");
      measure(5'h00, 32);
      measure(5'h01, 64);
      measure(5'h13, 32);
      bus_read(STATUS_OFF, rd);
      check(rd, 32'h0000_0101, "status reserved code");
      measure(5'h1f, 32);
      bus_write(CTRL_OFF, 32'h0);
      repeat (3) @(posedge ref_clk);
      check({31'h0, watchdog_on}, 32'h0, "soft off");
      // Unmapped and write-only places
      bus_write(12'h100, 32'hffff_ffff);
      bus_read(12'h100, rd);
      check(rd, 32'h0, "unmapped read");
      check({31'h0, hresp}, {31'h0, HRESP_OKAY}, "okay response");
      bus_read(RESTART_OFF, rd);
      check(rd, 32'h0, "restart read");
      bus_read(CTRL_OFF, rd);
      check(rd, 32'h0, "ctrl untouched");
      // Locked interval, soft bit still writable
      do_reset(5'h07, 2'h1);
      bus_read(CTRL_OFF, rd);
      check(rd, 32'h0000_000e, "locked reset value");
      bus_write(CTRL_OFF, 32'h0000_0007);
      bus_read(CTRL_OFF, rd);
      check(rd, 32'h0000_000f, "locked write");
      bus_read(STATUS_OFF, rd);
      check(rd, 32'h0000_014f, "locked status");
      // Fixed modes ignore the soft bit; write its opposite
      for (int i = 0; i < 3; i++) begin
         mode = (i == 0) ? 2'h0 : 2'(i + 1);
         do_reset(5'h1f, mode);
         // Keep the reset interval so only the soft bit differs
         bus_write(CTRL_OFF, {26'h0, INTERVAL_RST, ~mode[1]});
         repeat (3) @(posedge ref_clk);
         check({31'h0, watchdog_on}, {31'h0, mode[1]}, "fixed mode on");
         bus_read(STATUS_OFF, rd);
         check(rd, {22'h0, mode, 2'h0, INTERVAL_RST, mode[1]}, "fixed status");
      end
      // Locked shortest code: written code must not change the interval
      do_reset(5'h00, 2'h2);
      measure(5'h05, 32);
      give_verdict();
   end
endmodule : testbench
